/* File: rtl/spd_sensor_defines.svh */
// constants for the module thermal sensor and presence-detect store
// assumes inclusion by the package and by the design modules
`ifndef SPD_SENSOR_DEFINES_SVH
`define SPD_SENSOR_DEFINES_SVH

`define SPD_BYTES        512
`define SPD_ADDR_W       9
`define SPD_BLOCKS       4
`define SPD_BLK_MSB      8
`define SPD_BLK_LSB      7
`define SPD_SWP_LIMIT    9'h180
`define SPD_RSVD_LO      9'h100
`define SPD_RSVD_HI      9'h13F
`define SPD_RSVD_DATA    8'h00
`define SPD_BLANK_DATA   8'hFF
`define SPD_PRELOAD_SEED 8'h5A
`define SENSOR_ADDR      7'h18
`define SPD_ADDR_BASE    6'h28
`define SCL_MAX_HZ       1000000
`define CLK_HZ           100000000
`define SCL_MIN_HALF_CYC ((`CLK_HZ / `SCL_MAX_HZ) / 4)
`define TEMP_BYTES_W     16
`define ACK_BIT_CNT      4'h8
`define LAST_BIT_CNT     4'h7

`endif

/* File: rtl/spd_sensor_pkg.sv */
// types shared by the sensor core and its serial link engine
// assumes the defines header is on the include path
package spd_sensor_pkg;
    `include "spd_sensor_defines.svh"

    typedef enum logic [1:0] {
        MODE_INTERRUPT,
        MODE_COMPARATOR,
        MODE_CRIT_ONLY
    } alert_mode_t;

    typedef enum logic [1:0] {
        TGT_NONE,
        TGT_SENSOR,
        TGT_STORE
    } target_t;

    typedef enum logic [2:0] {
        L_IDLE,
        L_RX,
        L_ACK,
        L_TX,
        L_RACK
    } link_state_t;

    typedef struct packed {
        logic        s1_scl;
        logic        s2_scl;
        logic        p_scl;
        logic        s1_sda;
        logic        s2_sda;
        logic        p_sda;
        link_state_t state;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic        first;
        logic        rw;
        logic        mack;
        logic        drive_low;
        logic        stop;
        logic        rx_valid;
        logic        tx_taken;
    } link_state_reg_t;
endpackage : spd_sensor_pkg

/* File: rtl/byte_link_if.sv */
// byte-level handshake between the serial link engine and the sensor core
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface byte_link_if;
    logic       stop;
    logic       rx_valid;
    logic       rx_first;
    logic [7:0] rx_data;
    logic       tx_taken;
    logic       ack;
    logic [7:0] tx_data;

    modport link (
        output stop,
        output rx_valid,
        output rx_first,
        output rx_data,
        output tx_taken,
        input  ack,
        input  tx_data
    );

    modport core (
        input  stop,
        input  rx_valid,
        input  rx_first,
        input  rx_data,
        input  tx_taken,
        output ack,
        output tx_data
    );
endinterface : byte_link_if

/* File: rtl/serial_link.sv */
// two-wire slave bit engine: start/stop detection, byte shift, acknowledge
// assumes scl and sda come from pins outside the clk domain
`timescale 1ns/10ps
`include "spd_sensor_defines.svh"
module serial_link
    import spd_sensor_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  scl,
    input  wire logic  sda_in,
    output logic       sda_oe,
    byte_link_if.link  bus
);
    link_state_reg_t st;
    link_state_reg_t next_st;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_seen;
    logic            stop_seen;

    // edges of the synchronised lines, first stages are not read here
    assign scl_rise   = st.s2_scl & ~st.p_scl;
    assign scl_fall   = ~st.s2_scl & st.p_scl;
    assign start_seen = st.s2_scl & st.p_scl & st.p_sda & ~st.s2_sda;
    assign stop_seen  = st.s2_scl & st.p_scl & ~st.p_sda & st.s2_sda;

    assign sda_oe       = st.drive_low;
    assign bus.stop     = st.stop;
    assign bus.rx_valid = st.rx_valid;
    assign bus.rx_first = st.first;
    assign bus.rx_data  = st.sh;
    assign bus.tx_taken = st.tx_taken;

    always_comb begin
        next_st          = st;
        next_st.s1_scl   = scl;
        next_st.s2_scl   = st.s1_scl;
        next_st.p_scl    = st.s2_scl;
        next_st.s1_sda   = sda_in;
        next_st.s2_sda   = st.s1_sda;
        next_st.p_sda    = st.s2_sda;
        next_st.stop     = 1'b0;
        next_st.rx_valid = 1'b0;
        next_st.tx_taken = 1'b0;
        unique case (st.state)
            L_IDLE: begin
            end
            L_RX: begin
                if (scl_rise) begin
                    next_st.sh  = {st.sh[6:0], st.s2_sda};
                    next_st.cnt = st.cnt + 4'h1;
                    if (st.cnt == `LAST_BIT_CNT) begin
                        next_st.rx_valid = 1'b1;
                        next_st.rw       = st.s2_sda;
                    end
                end
                if (scl_fall && st.cnt == `ACK_BIT_CNT) begin
                    next_st.drive_low = bus.ack;
                    next_st.state     = bus.ack ? L_ACK : L_IDLE;
                end
            end
            L_ACK: begin
                if (scl_fall) begin
                    next_st.cnt   = 4'h0;
                    next_st.first = 1'b0;
                    if (st.first && st.rw) begin
                        next_st.sh        = bus.tx_data;
                        next_st.tx_taken  = 1'b1;
                        next_st.drive_low = ~bus.tx_data[7];
                        next_st.state     = L_TX;
                    end else begin
                        next_st.drive_low = 1'b0;
                        next_st.state     = L_RX;
                    end
                end
            end
            L_TX: begin
                if (scl_fall) begin
                    if (st.cnt == `LAST_BIT_CNT) begin
                        next_st.drive_low = 1'b0;
                        next_st.state     = L_RACK;
                    end else begin
                        next_st.cnt       = st.cnt + 4'h1;
                        next_st.sh        = {st.sh[6:0], 1'b0};
                        next_st.drive_low = ~st.sh[6];
                    end
                end
            end
            L_RACK: begin
                if (scl_rise) begin
                    next_st.mack = ~st.s2_sda;
                end
                if (scl_fall) begin
                    next_st.cnt = 4'h0;
                    if (st.mack) begin
                        next_st.sh        = bus.tx_data;
                        next_st.tx_taken  = 1'b1;
                        next_st.drive_low = ~bus.tx_data[7];
                        next_st.state     = L_TX;
                    end else begin
                        next_st.state = L_IDLE;
                    end
                end
            end
        endcase
        if (start_seen) begin
            next_st.state     = L_RX;
            next_st.cnt       = 4'h0;
            next_st.first     = 1'b1;
            next_st.drive_low = 1'b0;
        end
        if (stop_seen) begin
            next_st.state     = L_IDLE;
            next_st.drive_low = 1'b0;
            next_st.stop      = 1'b1;
        end
        if (rst) begin
            next_st        = '0;
            next_st.s1_scl = 1'b1;
            next_st.s2_scl = 1'b1;
            next_st.p_scl  = 1'b1;
            next_st.s1_sda = 1'b1;
            next_st.s2_sda = 1'b1;
            next_st.p_sda  = 1'b1;
            next_st.state  = L_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end
endmodule : serial_link

/* File: rtl/thermal_spd_top.sv */
// thermal sensor with alert pin and 512-byte presence-detect store
// assumes one two-wire bus from the host; temperature samples on clk
`timescale 1ns/10ps
`include "spd_sensor_defines.svh"
module thermal_spd_top
    import spd_sensor_pkg::*;
#(
    parameter int TW = 13
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          scl,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe,
    output logic               event_n_out,
    output logic               event_n_oe,
    input  wire logic [TW-1:0] temp_sample,
    input  wire logic          temp_sample_valid,
    input  wire alert_mode_t   alert_mode,
    input  wire logic          event_enable,
    input  wire logic [TW-1:0] upper_limit,
    input  wire logic [TW-1:0] lower_limit,
    input  wire logic [TW-1:0] critical_temp_limit,
    input  wire logic [TW-1:0] crit_hysteresis,
    input  wire logic          event_clear,
    input  wire logic          soft_wp,
    input  wire logic [3:0]    block_wp,
    output logic [TW-1:0]      temp_value,
    output logic               event_status,
    output logic               crit_status
);
    typedef struct packed {
        logic [`SPD_BYTES-1:0][7:0]  mem;
        logic [TW-1:0]               temp;
        logic                        win_prev;
        logic                        evt_latch;
        logic                        crit_hold;
        logic                        alert;
        target_t                     target;
        logic                        got_word;
        logic [`SPD_ADDR_W-1:0]      ptr;
        logic                        byte_sel;
        logic [7:0]                  snap_lo;
        logic                        ack;
        logic [7:0]                  tx_data;
    } core_state_t;

    core_state_t                 st;
    core_state_t                 next_st;
    logic                        win_out;
    logic                        crit_over;
    logic                        crit_under;
    logic signed [TW+1:0]        crit_release;
    logic [`TEMP_BYTES_W-1:0]    temp_wide;
    logic [`SPD_ADDR_W-1:0]      ptr_inc;

    byte_link_if link_bus ();

    serial_link u_link (
        .clk    (clk),
        .rst    (rst),
        .scl    (scl),
        .sda_in (sda_in),
        .sda_oe (sda_oe),
        .bus    (link_bus)
    );

    // preload content of the store after reset
    function automatic logic [7:0] preload_byte(input logic [`SPD_ADDR_W-1:0] a);
        logic [7:0] v;
        v = `SPD_BLANK_DATA;
        if (a >= `SPD_RSVD_LO && a <= `SPD_RSVD_HI) begin
            v = `SPD_RSVD_DATA;
        end else if (a < `SPD_SWP_LIMIT) begin
            v = a[7:0] ^ `SPD_PRELOAD_SEED;
        end
        return v;
    endfunction : preload_byte

    // write guard per byte address
    function automatic logic locked(input logic [`SPD_ADDR_W-1:0] a,
                                    input logic                   swp,
                                    input logic [3:0]             bwp);
        logic r;
        r = bwp[a[`SPD_BLK_MSB:`SPD_BLK_LSB]];
        if (swp && a < `SPD_SWP_LIMIT) begin
            r = 1'b1;
        end
        if (a >= `SPD_RSVD_LO && a <= `SPD_RSVD_HI) begin
            r = 1'b1;
        end
        return r;
    endfunction : locked

    assign sda_out     = 1'b0;
    assign event_n_out = 1'b0;
    assign event_n_oe  = st.alert;
    assign temp_value  = st.temp;
    assign event_status = st.evt_latch;
    assign crit_status = st.crit_hold;

    assign link_bus.ack     = st.ack;
    assign link_bus.tx_data = st.tx_data;

    // threshold comparisons on the stored reading
    assign win_out = ($signed(st.temp) > $signed(upper_limit)) ||
                     ($signed(st.temp) < $signed(lower_limit));
    assign crit_over = $signed(st.temp) > $signed(critical_temp_limit);
    // two guard bits so limit minus a large hysteresis cannot wrap
    assign crit_release = $signed({{2{critical_temp_limit[TW-1]}}, critical_temp_limit}) -
                          $signed({2'b00, crit_hysteresis});
    assign crit_under = $signed({{2{st.temp[TW-1]}}, st.temp}) < crit_release;
    assign temp_wide = {{(`TEMP_BYTES_W-TW){st.temp[TW-1]}}, st.temp};
    assign ptr_inc = {st.ptr[`SPD_BLK_MSB], st.ptr[7:0] + 8'h01};

    always_comb begin
        next_st = st;

        // sensor: every sample refreshes the reading
        if (temp_sample_valid) begin
            next_st.temp = temp_sample;
        end

        // interrupt latch: set wins over a simultaneous clear
        next_st.win_prev = win_out;
        if (event_clear) begin
            next_st.evt_latch = 1'b0;
        end
        if (win_out && !st.win_prev) begin
            next_st.evt_latch = 1'b1;
        end

        // critical comparison with hysteresis on release
        if (crit_over) begin
            next_st.crit_hold = 1'b1;
        end else if (crit_under) begin
            next_st.crit_hold = 1'b0;
        end

        // alert pin drive, sensor state only
        unique case (alert_mode)
            MODE_INTERRUPT: begin
                next_st.alert = st.evt_latch | st.crit_hold;
            end
            MODE_COMPARATOR: begin
                next_st.alert = win_out | st.crit_hold;
            end
            MODE_CRIT_ONLY: begin
                next_st.alert = st.crit_hold;
            end
            default: begin
                next_st.alert = 1'b0;
            end
        endcase
        next_st.alert = next_st.alert & event_enable;

        // serial slave: address phase picks sensor or store
        if (link_bus.rx_valid && link_bus.rx_first) begin
            next_st.byte_sel = 1'b0;
            next_st.got_word = 1'b0;
            if (link_bus.rx_data[7:1] == `SENSOR_ADDR) begin
                next_st.target  = TGT_SENSOR;
                next_st.ack     = 1'b1;
                next_st.tx_data = temp_wide[15:8];
                next_st.snap_lo = temp_wide[7:0];
            end else if (link_bus.rx_data[7:2] == `SPD_ADDR_BASE) begin
                next_st.target  = TGT_STORE;
                next_st.ack     = 1'b1;
                next_st.ptr     = {link_bus.rx_data[1], st.ptr[7:0]};
                next_st.tx_data = st.mem[{link_bus.rx_data[1], st.ptr[7:0]}];
            end else begin
                next_st.target = TGT_NONE;
                next_st.ack    = 1'b0;
            end
        end else if (link_bus.rx_valid) begin
            next_st.ack = (st.target != TGT_NONE);
            if (st.target == TGT_STORE) begin
                if (!st.got_word) begin
                    next_st.got_word = 1'b1;
                    next_st.ptr      = {st.ptr[`SPD_BLK_MSB], link_bus.rx_data};
                end else begin
                    if (!locked(st.ptr, soft_wp, block_wp)) begin
                        next_st.mem[st.ptr] = link_bus.rx_data;
                    end
                    next_st.ptr = ptr_inc;
                end
            end
        end

        // read data for the byte after the one just taken
        if (link_bus.tx_taken) begin
            if (st.target == TGT_STORE) begin
                next_st.ptr     = ptr_inc;
                next_st.tx_data = st.mem[ptr_inc];
            end else if (st.target == TGT_SENSOR) begin
                next_st.byte_sel = ~st.byte_sel;
                if (!st.byte_sel) begin
                    next_st.tx_data = st.snap_lo;
                end else begin
                    next_st.tx_data = temp_wide[15:8];
                    next_st.snap_lo = temp_wide[7:0];
                end
            end
        end

        if (link_bus.stop) begin
            next_st.target = TGT_NONE;
            next_st.ack    = 1'b0;
        end

        if (rst) begin
            next_st        = '0;
            next_st.target = TGT_NONE;
            for (int i = 0; i < `SPD_BYTES; i++) begin
                next_st.mem[i] = preload_byte(`SPD_ADDR_W'(i));
            end
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end
endmodule : thermal_spd_top

/* File: tb/thermal_spd_asserts.sv */
// port checker for the sensor and presence-detect store top
// assumes binding onto thermal_spd_top, one clock domain
`timescale 1ns/10ps
module thermal_spd_asserts
    import spd_sensor_pkg::*;
#(
    parameter int TW = 13
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          scl,
    input wire logic          sda_in,
    input wire logic          sda_out,
    input wire logic          sda_oe,
    input wire logic          event_n_out,
    input wire logic          event_n_oe,
    input wire logic [TW-1:0] temp_sample,
    input wire logic          temp_sample_valid,
    input wire alert_mode_t   alert_mode,
    input wire logic          event_enable,
    input wire logic [TW-1:0] upper_limit,
    input wire logic [TW-1:0] lower_limit,
    input wire logic [TW-1:0] critical_temp_limit,
    input wire logic [TW-1:0] crit_hysteresis,
    input wire logic          event_clear,
    input wire logic          soft_wp,
    input wire logic [3:0]    block_wp,
    input wire logic [TW-1:0] temp_value,
    input wire logic          event_status,
    input wire logic          crit_status
);
    int   t, up, lw, cl, hy;
    logic in_win, ge_hyst;
    assign t = signed'(temp_value);
    assign up = signed'(upper_limit);
    assign lw = signed'(lower_limit);
    assign cl = signed'(critical_temp_limit);
    assign hy = crit_hysteresis;
    assign in_win = t <= up && t >= lw;
    assign ge_hyst = t >= cl - hy;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_clear: assert property ($fell(rst) |-> !event_n_oe && !sda_oe && !crit_status)
        else $error("outputs not clear after reset");
    a_temp_refresh: assert property (temp_sample_valid |=> temp_value == $past(temp_sample))
        else $error("temperature not refreshed");
    a_drain_low: assert property (sda_out == 1'b0 && event_n_out == 1'b0)
        else $error("open drain output driven high");
    a_crit_set: assert property (t > cl |=> crit_status)
        else $error("critical state not set");
    a_crit_hold: assert property (crit_status |=> crit_status == $past(ge_hyst))
        else $error("critical hysteresis wrong");
    a_crit_alert: assert property (crit_status && event_enable && alert_mode != 2'h3 |=> event_n_oe)
        else $error("critical state without alert");
    a_enable_gate: assert property (!event_enable [*2] |-> !event_n_oe)
        else $error("alert while disabled");
    a_crit_only: assert property (alert_mode == MODE_CRIT_ONLY && !crit_status |=> !event_n_oe)
        else $error("alert in critical-only mode");
    a_comp_release: assert property ((alert_mode == MODE_COMPARATOR && in_win
        && t <= cl && !crit_status) [*3] |-> !event_n_oe)
        else $error("comparator alert not released");
    a_int_hold: assert property (alert_mode == MODE_INTERRUPT && event_status
        && !event_clear |=> event_status)
        else $error("interrupt latch dropped");
    a_int_clear: assert property (event_clear && in_win |=> !event_status)
        else $error("interrupt latch not cleared");
endmodule : thermal_spd_asserts

bind thermal_spd_top thermal_spd_asserts #(.TW(TW)) chk (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .event_n_out(event_n_out), .event_n_oe(event_n_oe), .temp_sample(temp_sample),
    .temp_sample_valid(temp_sample_valid), .alert_mode(alert_mode),
    .event_enable(event_enable), .upper_limit(upper_limit), .lower_limit(lower_limit),
    .critical_temp_limit(critical_temp_limit), .crit_hysteresis(crit_hysteresis),
    .event_clear(event_clear), .soft_wp(soft_wp), .block_wp(block_wp),
    .temp_value(temp_value), .event_status(event_status), .crit_status(crit_status)
);

/* File: tb/i2c_host_model.sv */
// two-wire host model: start, stop, byte write and byte read
// assumes a pulled-up data line; the serial clock idles high
`timescale 1ns/10ps
module i2c_host_model (
    output logic      scl,
    output logic      sda_in,
    input  wire logic sda_oe
);
    localparam real Q = 31.25;
    logic drv;
    assign sda_in = drv & ~sda_oe;
    initial begin
        scl = 1'b1;
        drv = 1'b1;
    end
    task automatic bit_io(input logic b, output logic r);
        #Q drv = b;
        #Q scl = 1'b1;
        #(2*Q-1) r = sda_in;
        #1 scl = 1'b0;
    endtask : bit_io
    task automatic start;
        #Q drv = 1'b1;
        #Q scl = 1'b1;
        #Q drv = 1'b0;
        #Q scl = 1'b0;
    endtask : start
    task automatic stop;
        #Q drv = 1'b0;
        #Q scl = 1'b1;
        #Q drv = 1'b1;
        #Q;
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~mack, r);
    endtask : rbyte
endmodule : i2c_host_model

/* File: tb/tb.sv */
// self-checking bench for the sensor and presence-detect store top
// assumes the host model drives the serial pins; clk at 100 MHz
`timescale 1ns/10ps
`include "spd_sensor_defines.svh"
module tb;
    import spd_sensor_pkg::*;
    localparam int TW = 13;
    logic          clk, rst, scl, sda_in, sda_out, sda_oe, event_n_out, event_n_oe;
    logic [TW-1:0] temp_sample, upper_limit, lower_limit, critical_temp_limit;
    logic [TW-1:0] crit_hysteresis, temp_value;
    logic          temp_sample_valid, event_enable, event_clear, soft_wp;
    logic          event_status, crit_status, ack, a2;
    logic [3:0]    block_wp;
    logic [7:0]    d, hi;
    logic [8:0]    a;
    alert_mode_t   alert_mode, m;
    int            mismatches = 0;
    int            checked = 0;
    int            v;
    logic [8:0]    tbl [10] = '{9'h000, 9'h07F, 9'h080, 9'h0FF, 9'h100,
                                9'h13F, 9'h140, 9'h17F, 9'h180, 9'h1FF};

    thermal_spd_top #(.TW(TW)) uut (
        .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .event_n_out(event_n_out), .event_n_oe(event_n_oe), .temp_sample(temp_sample),
        .temp_sample_valid(temp_sample_valid), .alert_mode(alert_mode),
        .event_enable(event_enable), .upper_limit(upper_limit), .lower_limit(lower_limit),
        .critical_temp_limit(critical_temp_limit), .crit_hysteresis(crit_hysteresis),
        .event_clear(event_clear), .soft_wp(soft_wp), .block_wp(block_wp),
        .temp_value(temp_value), .event_status(event_status), .crit_status(crit_status)
    );
    i2c_host_model host (.scl(scl), .sda_in(sda_in), .sda_oe(sda_oe));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic feed(input int t);
        step(1);
        temp_sample = t[TW-1:0];
        temp_sample_valid = 1'b1;
        step(1);
        temp_sample_valid = 1'b0;
        step(3);
    endtask : feed
    task automatic pulse_clear;
        event_clear = 1'b1;
        step(1);
        event_clear = 1'b0;
        step(2);
    endtask : pulse_clear
    function automatic logic [7:0] pre(input logic [8:0] adr);
        if (adr >= 9'h180) return 8'hFF;
        if (adr >= 9'h100 && adr <= 9'h13F) return 8'h00;
        return adr[7:0] ^ 8'h5A;
    endfunction : pre
    task automatic store_ptr(input logic [8:0] adr);
        host.start();
        host.wbyte({`SPD_ADDR_BASE, adr[8], 1'b0}, ack);
        host.wbyte(adr[7:0], a2);
        check("store ack", {ack, a2}, 2'b11);
    endtask : store_ptr
    task automatic store_write(input logic [8:0] adr, input logic [7:0] b);
        store_ptr(adr);
        host.wbyte(b, ack);
        host.stop();
        check("write ack", ack, 1'b1);
    endtask : store_write
    task automatic store_read(input logic [8:0] adr, output logic [7:0] b);
        store_ptr(adr);
        host.start();
        host.wbyte({`SPD_ADDR_BASE, adr[8], 1'b1}, ack);
        host.rbyte(1'b0, b);
        host.stop();
    endtask : store_read
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #500000;
        mismatches++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        {temp_sample, temp_sample_valid, event_clear, soft_wp, block_wp} = '0;
        alert_mode = MODE_COMPARATOR;
        event_enable = 1'b1;
        upper_limit = 13'h190;
        lower_limit = 13'h000;
        critical_temp_limit = 13'h320;
        crit_hysteresis = 13'h020;
        void'($urandom(32'h2079));
        step(6);
        rst = 1'b0;
        step(3);
        for (int i = 0; i < 16; i++) begin
            v = $urandom;
            feed(v);
            check("temp value", temp_value, v[TW-1:0]);
        end
        host.start();
        host.wbyte({`SENSOR_ADDR, 1'b1}, ack);
        host.rbyte(1'b1, hi);
        host.rbyte(1'b0, d);
        host.stop();
        check("sensor ack", ack, 1'b1);
        check("temp read", {hi, d}, 16'(signed'(temp_sample)));
        host.start();
        host.wbyte({7'h33, 1'b0}, ack);
        host.stop();
        check("foreign address", ack, 1'b0);
        $display("test temperature and sensor read done");
        for (int k = 0; k < 3; k++) begin
            m = alert_mode_t'(k);
            alert_mode = m;
            feed(100);
            pulse_clear();
            check("alert idle", event_n_oe, 1'b0);
            feed(500);
            check("above upper", event_n_oe, m != MODE_CRIT_ONLY);
            feed(100);
            check("back in window", event_n_oe, m == MODE_INTERRUPT);
            check("event latch", event_status, 1'b1);
            pulse_clear();
            check("after clear", event_n_oe, 1'b0);
            feed(900);
            check("above critical", event_n_oe, 1'b1);
            feed(780);
            check("in hysteresis", crit_status, 1'b1);
            feed(700);
            check("below hysteresis", event_n_oe, m != MODE_CRIT_ONLY);
        end
        feed(900);
        event_enable = 1'b0;
        step(3);
        check("alert disabled", event_n_oe, 1'b0);
        event_enable = 1'b1;
        alert_mode = alert_mode_t'(2'h3);
        step(3);
        check("alert off mode", event_n_oe, 1'b0);
        alert_mode = MODE_CRIT_ONLY;
        feed(100);
        $display("test alert modes done");
        for (int i = 0; i < 14; i++) begin
            a = i < 10 ? tbl[i] : 9'($urandom);
            store_read(a, d);
            check("preload", d, pre(a));
        end
        check("alert untouched", event_n_oe, 1'b0);
        step(1);
        soft_wp = 1'b1;
        store_write(9'h045, 8'hC3);
        store_write(9'h1C0, 8'h3C);
        store_write(9'h110, 8'h77);
        store_read(9'h045, d);
        check("soft protect", d, pre(9'h045));
        store_read(9'h1C0, d);
        check("top block", d, 8'h3C);
        store_read(9'h110, d);
        check("reserved", d, 8'h00);
        step(1);
        soft_wp = 1'b0;
        block_wp = 4'h8;
        store_write(9'h1C0, 8'h99);
        store_write(9'h045, 8'hC3);
        store_read(9'h1C0, d);
        check("block protect", d, 8'h3C);
        store_read(9'h045, d);
        check("protect lifted", d, 8'hC3);
        $display("test store done");
        print_verdict();
    end
endmodule : tb
